// >>> hw/ctbd_timebase.v
// correlator timebase dividers and channel-group select behind apb
// Functional notes
// - group select bits 11..0 each enable multi-channel writes to a channel.
// - hardware or software master reset clears all group select bits.
// - 13-bit down counter gives accumulation interrupt, reloads preset at zero.
// - interrupt counter steps P down to 0 then P: period P+1.
// - counters step once per 7 clocks real mode, 6 clocks complex mode.
// - interrupt divider write loads bits 12..0 as preset, ignores 15..13.
// - edge on period or mode bit loads one of four fixed presets.
// - real mode presets 0x0b45 short, 0x1313 long; short also at reset.
// - complex mode presets 0x0b81 short, 0x1379 long.
// - divider writes and mode edges both overwrite the preset, freely mixed.
// - 21-bit down counter gives tick at zero, reloads, divides by P+1.
// - tick upper write holds bits 4..0; next lower write moves all 21.
// - tick lower write fills low 16 bits with held upper 5 bits.
// - mode edge loads tick preset 0x08b823 real, 0x08e6a4 complex; real at reset.
// - tick upper write alone never changes the tick preset.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "ctbd_regs.vh"

module ctbd_timebase
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        mc_write,
	output reg  [11:0] mc_write_en,
	output reg  [11:0] channel_group_select,
	output reg         accumulation_interrupt,
	output reg         measurement_tick,
	output reg         real_input_mode,
	output reg         irq
);

	reg  [11:0] group_q;
	reg  [12:0] int_preset_q;
	reg  [12:0] int_cnt_q;
	reg  [20:0] tick_preset_q;
	reg  [20:0] tick_cnt_q;
	reg  [4:0]  tick_upper_q;
	reg         period_q;
	reg         fe_mode_q;
	reg  [2:0]  phase_q;
	reg  [1:0]  status_q;
	reg  [1:0]  mask_q;
	reg         soft_reset_q;

	wire        acc_phase;
	wire        wr_en;
	wire        rd_en;
	wire        addr_ok;
	wire        mc_step;
	wire        int_zero;
	wire        tick_zero;
	wire        new_period;
	wire        new_fe;
	wire        setup_wr;
	wire        mode_edge;
	wire        period_edge;
	wire [1:0]  events;
	reg  [12:0] auto_int;
	reg  [31:0] rdata_d;
	wire        group_wr;
	wire        int_div_wr;
	wire        tick_upper_wr;
	wire        tick_lower_wr;
	reg  [11:0] group_d;
	reg  [12:0] int_preset_d;
	reg  [20:0] tick_preset_d;
	reg  [4:0]  tick_upper_d;
	reg  [20:0] auto_tick;
	reg  [2:0]  phase_d;
	reg  [12:0] int_cnt_d;
	reg  [20:0] tick_cnt_d;

	assign acc_phase = psel & penable & ~pready;
	assign wr_en = acc_phase & pwrite & addr_ok;
	assign rd_en = acc_phase & ~pwrite;
	assign addr_ok = (paddr == `CTBD_OFF_GROUP_SEL) |
		(paddr == `CTBD_OFF_INT_DIV) |
		(paddr == `CTBD_OFF_TICK_UPPER) |
		(paddr == `CTBD_OFF_TICK_LOWER) |
		(paddr == `CTBD_OFF_SETUP) |
		(paddr == `CTBD_OFF_IRQ_STATUS) |
		(paddr == `CTBD_OFF_IRQ_MASK) |
		(paddr == `CTBD_OFF_CONTROL) |
		(paddr == `CTBD_OFF_INT_COUNT) |
		(paddr == `CTBD_OFF_TICK_COUNT);

	// multi-phase clock enable, 7 or 6 master clocks
	assign mc_step = fe_mode_q ? (phase_q == `CTBD_PHASE_CPLX) :
		(phase_q == `CTBD_PHASE_REAL);
	assign int_zero = (int_cnt_q == 13'h0000);
	assign tick_zero = (tick_cnt_q == 21'h000000);

	assign setup_wr = wr_en & (paddr == `CTBD_OFF_SETUP);
	assign new_period = pwdata[`CTBD_SETUP_PERIOD];
	assign new_fe = pwdata[`CTBD_SETUP_FE_MODE];
	assign period_edge = setup_wr & (new_period != period_q);
	assign mode_edge = setup_wr & (new_fe != fe_mode_q);
	assign events = {mc_step & tick_zero, mc_step & int_zero};

	// register write strobes
	assign group_wr = wr_en & (paddr == `CTBD_OFF_GROUP_SEL);
	assign int_div_wr = wr_en & (paddr == `CTBD_OFF_INT_DIV);
	assign tick_upper_wr = wr_en & (paddr == `CTBD_OFF_TICK_UPPER);
	assign tick_lower_wr = wr_en & (paddr == `CTBD_OFF_TICK_LOWER);

	// edge presets follow the new bit values, not the old ones
	always @*
	begin
		if (new_fe)
		begin
			auto_tick = `CTBD_TICK_CPLX;
		end
		else
		begin
			auto_tick = `CTBD_TICK_REAL;
		end
	end

	always @*
	begin
		case ({new_fe, new_period})
			2'b00: auto_int = `CTBD_INT_REAL_SHORT;
			2'b01: auto_int = `CTBD_INT_REAL_LONG;
			2'b10: auto_int = `CTBD_INT_CPLX_SHORT;
			default: auto_int = `CTBD_INT_CPLX_LONG;
		endcase
	end

	always @*
	begin
		rdata_d = 32'h00000000;
		case (paddr)
			`CTBD_OFF_GROUP_SEL: rdata_d = {20'h00000, group_q};
			`CTBD_OFF_INT_DIV: rdata_d = {19'h00000, int_preset_q};
			`CTBD_OFF_TICK_UPPER: rdata_d = {27'h0000000, tick_upper_q};
			`CTBD_OFF_TICK_LOWER: rdata_d = {11'h000, tick_preset_q};
			`CTBD_OFF_SETUP: rdata_d = {30'h00000000, period_q, fe_mode_q};
			`CTBD_OFF_IRQ_STATUS: rdata_d = {30'h00000000, status_q};
			`CTBD_OFF_IRQ_MASK: rdata_d = {30'h00000000, mask_q};
			`CTBD_OFF_CONTROL: rdata_d = 32'h00000000;
			`CTBD_OFF_INT_COUNT: rdata_d = {19'h00000, int_cnt_q};
			`CTBD_OFF_TICK_COUNT: rdata_d = {11'h000, tick_cnt_q};
			default: rdata_d = 32'h00000000;
		endcase
	end

	// apb slave: one wait state, pready pulses in the second access cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= acc_phase;
			pslverr <= acc_phase & ~addr_ok;
			prdata <= rd_en ? rdata_d : 32'h00000000;
		end
	end

	// control, setup and interrupt registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			period_q <= 1'b0;
			fe_mode_q <= 1'b0;
			mask_q <= 2'h0;
			status_q <= 2'h0;
			soft_reset_q <= 1'b0;
		end
		else
		begin
			soft_reset_q <= wr_en & (paddr == `CTBD_OFF_CONTROL) &
				pwdata[`CTBD_CTRL_SOFT_RESET];
			if (setup_wr)
			begin
				period_q <= new_period;
				fe_mode_q <= new_fe;
			end
			if (wr_en & (paddr == `CTBD_OFF_IRQ_MASK))
				mask_q <= pwdata[1:0];
			// set wins over write-one-to-clear
			if (wr_en & (paddr == `CTBD_OFF_IRQ_STATUS))
				status_q <= (status_q & ~pwdata[1:0]) | events;
			else
				status_q <= status_q | events;
		end
	end

	// channel group select, cleared by either master reset
	always @*
	begin
		group_d = group_q;
		if (soft_reset_q)
		begin
			group_d = 12'h000;
		end
		else if (group_wr)
		begin
			group_d = pwdata[11:0];
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			group_q <= 12'h000;
		else
			group_q <= group_d;
	end

	// next presets: a mode or period edge beats a divider write
	always @*
	begin
		int_preset_d = int_preset_q;
		tick_preset_d = tick_preset_q;
		tick_upper_d = tick_upper_q;
		if (period_edge | mode_edge)
		begin
			int_preset_d = auto_int;
		end
		else if (int_div_wr)
		begin
			int_preset_d = pwdata[12:0];
		end
		// upper bits wait locally, the live preset stays untouched
		if (tick_upper_wr)
		begin
			tick_upper_d = pwdata[4:0];
		end
		if (mode_edge)
		begin
			tick_preset_d = auto_tick;
		end
		else if (tick_lower_wr)
		begin
			tick_preset_d = {tick_upper_q, pwdata[15:0]};
		end
	end

	// next counts: a new preset only takes hold at the next reload
	always @*
	begin
		phase_d = phase_q + 3'h1;
		int_cnt_d = int_cnt_q;
		tick_cnt_d = tick_cnt_q;
		if (mc_step)
		begin
			phase_d = 3'h0;
			if (int_zero)
			begin
				int_cnt_d = int_preset_q;
			end
			else
			begin
				int_cnt_d = int_cnt_q - 13'h0001;
			end
			if (tick_zero)
			begin
				tick_cnt_d = tick_preset_q;
			end
			else
			begin
				tick_cnt_d = tick_cnt_q - 21'h000001;
			end
		end
	end

	// presets, multi-phase divider and the two down counters
	// soft reset leaves all of these running
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_preset_q <= `CTBD_INT_REAL_SHORT;
			tick_preset_q <= `CTBD_TICK_REAL;
			tick_upper_q <= 5'h00;
			phase_q <= 3'h0;
			int_cnt_q <= `CTBD_INT_REAL_SHORT;
			tick_cnt_q <= `CTBD_TICK_REAL;
		end
		else
		begin
			int_preset_q <= int_preset_d;
			tick_preset_q <= tick_preset_d;
			tick_upper_q <= tick_upper_d;
			phase_q <= phase_d;
			int_cnt_q <= int_cnt_d;
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// registered outputs
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			accumulation_interrupt <= 1'b0;
			measurement_tick <= 1'b0;
			mc_write_en <= 12'h000;
			channel_group_select <= 12'h000;
			real_input_mode <= 1'b1;
			irq <= 1'b0;
		end
		else
		begin
			accumulation_interrupt <= events[`CTBD_IRQ_ACCUM];
			measurement_tick <= events[`CTBD_IRQ_TICK];
			mc_write_en <= mc_write ? group_q : 12'h000;
			channel_group_select <= group_q;
			real_input_mode <= ~fe_mode_q;
			irq <= |(status_q & mask_q);
		end
	end

endmodule

`default_nettype wire

// >>> pkg/ctbd_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef CTBD_REGS_VH
`define CTBD_REGS_VH

`define CTBD_OFF_GROUP_SEL    12'h000
`define CTBD_OFF_INT_DIV      12'h004
`define CTBD_OFF_TICK_UPPER   12'h008
`define CTBD_OFF_TICK_LOWER   12'h00c
`define CTBD_OFF_SETUP        12'h010
`define CTBD_OFF_IRQ_STATUS   12'h014
`define CTBD_OFF_IRQ_MASK     12'h018
`define CTBD_OFF_CONTROL      12'h01c
`define CTBD_OFF_INT_COUNT    12'h020
`define CTBD_OFF_TICK_COUNT   12'h024

`define CTBD_SETUP_PERIOD     1
`define CTBD_SETUP_FE_MODE    0
`define CTBD_CTRL_SOFT_RESET  0
`define CTBD_IRQ_ACCUM        0
`define CTBD_IRQ_TICK         1

`define CTBD_INT_REAL_SHORT   13'h0b45
`define CTBD_INT_REAL_LONG    13'h1313
`define CTBD_INT_CPLX_SHORT   13'h0b81
`define CTBD_INT_CPLX_LONG    13'h1379
`define CTBD_TICK_REAL        21'h08b823
`define CTBD_TICK_CPLX        21'h08e6a4

`define CTBD_PHASE_REAL       3'h6
`define CTBD_PHASE_CPLX       3'h5

`endif

// >>> sim/ctbd_timebase_props.sv
// concurrent checks on the timebase block ports
`timescale 1ns/1ns
`default_nettype none
module ctbd_timebase_props
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        mc_write,
	input wire logic [11:0] mc_write_en,
	input wire logic [11:0] channel_group_select,
	input wire logic        accumulation_interrupt,
	input wire logic        measurement_tick
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_mc_copy: assert property (mc_write |=>
		mc_write_en == channel_group_select) else $error("mc enable wrong");
	a_mc_idle: assert property (!mc_write |=>
		mc_write_en == 12'h000) else $error("mc enable not idle");
	a_one_wait: assert property (psel && penable && !pready |=>
		pready) else $error("no answer after one wait");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_accum_gap: assert property (accumulation_interrupt |=>
		!accumulation_interrupt [*5]) else $error("accum pulses too close");
	a_tick_gap: assert property (measurement_tick |=>
		!measurement_tick [*5]) else $error("tick pulses too close");
	c_accum: cover property (accumulation_interrupt);
	c_mc: cover property (mc_write ##1 mc_write_en != 12'h000);
	c_err: cover property (pslverr);
endmodule
bind ctbd_timebase ctbd_timebase_props u_props (.*);
`default_nettype wire

// >>> sim/tb_correlator_timebase_dividers.sv
// self-checking bench for the correlator timebase block
`timescale 1ns/1ns
`default_nettype none
`include "ctbd_regs.vh"
module tb_correlator_timebase_dividers;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        mc_write = 0, pready, pslverr, irq, real_input_mode;
	logic        accumulation_interrupt, measurement_tick;
	logic [11:0] paddr = 0, mc_write_en, channel_group_select;
	logic [31:0] pwdata = 0, prdata, r;
	logic [32:0] exp_q[$];
	logic [1:0]  sv[4] = '{2'h1, 2'h3, 2'h2, 2'h0};
	logic [32:0] iv[4] = '{33'h0b81, 33'h1379, 33'h1313, 33'h0b45};
	logic [32:0] tv[4] = '{33'h08e6a4, 33'h08e6a4, 33'h08b823, 33'h08b823};
	int          fail_count = 0, checked = 0, cycles = 0, n, p;
	ctbd_timebase uut (
		.pclk                   (pclk),
		.presetn                (presetn),
		.psel                   (psel),
		.penable                (penable),
		.pwrite                 (pwrite),
		.paddr                  (paddr),
		.pwdata                 (pwdata),
		.prdata                 (prdata),
		.pready                 (pready),
		.pslverr                (pslverr),
		.mc_write               (mc_write),
		.mc_write_en            (mc_write_en),
		.channel_group_select   (channel_group_select),
		.accumulation_interrupt (accumulation_interrupt),
		.measurement_tick       (measurement_tick),
		.real_input_mode        (real_input_mode),
		.irq                    (irq)
	);
	always #4 pclk = ~pclk;
	task chk(input string s, input logic [32:0] e, input logic [32:0] v);
		checked++;
		if (v !== e)
		begin
			$display("Error %s expected %h seen %h", s, e, v);
			fail_count++;
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		if (!w)
			exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (50) @(posedge pclk);
	endtask
	// cycles between two accumulation pulses
	task gap(output int k);
		k = 0;
		while (accumulation_interrupt !== 1'b1)
			@(posedge pclk);
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (accumulation_interrupt !== 1'b1);
	endtask
	always @(posedge pclk)
		if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
			chk("read", exp_q.pop_front(), {pslverr, prdata});
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fail_count++;
			summarize();
		end
	end
	initial
	begin
		void'($urandom(32'hc247));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("mode", 1, real_input_mode);
		chk("group", 0, channel_group_select);
		apb(0, `CTBD_OFF_INT_DIV, 0, 33'h0b45);
		foreach (sv[i])
		begin
			apb(1, `CTBD_OFF_SETUP, sv[i], 0);
			apb(0, `CTBD_OFF_INT_DIV, 0, iv[i]);
			apb(0, `CTBD_OFF_TICK_LOWER, 0, tv[i]);
			chk("mode", !sv[i][0], real_input_mode);
		end
		apb(1, `CTBD_OFF_TICK_UPPER, 32'h1f, 0);
		apb(0, `CTBD_OFF_TICK_LOWER, 0, 33'h08b823);
		apb(1, `CTBD_OFF_INT_DIV, 32'hffff_e005, 0);
		apb(1, `CTBD_OFF_TICK_LOWER, 32'h0010, 0);
		apb(0, `CTBD_OFF_TICK_LOWER, 0, 33'h1f0010);
		apb(0, `CTBD_OFF_INT_DIV, 0, 33'h0005);
		r = $urandom;
		apb(1, `CTBD_OFF_GROUP_SEL, r, 0);
		apb(0, `CTBD_OFF_GROUP_SEL, 0, {21'h0, r[11:0]});
		mc_write <= 1'b1;
		@(posedge pclk);
		mc_write <= 1'b0;
		@(negedge pclk);
		chk("mc_en", r[11:0], mc_write_en);
		apb(1, `CTBD_OFF_CONTROL, 1, 0);
		repeat (2) @(posedge pclk);
		chk("group", 0, channel_group_select);
		apb(0, 12'h0f0, 0, 33'h1_0000_0000);
		p = $urandom_range(20, 3);
		apb(1, `CTBD_OFF_INT_DIV, p, 0);
		gap(n);
		chk("accum gap", (p + 1) * 7, n);
		chk("irq", 0, irq);
		apb(0, `CTBD_OFF_IRQ_STATUS, 0, 33'h1);
		apb(1, `CTBD_OFF_IRQ_MASK, 1, 0);
		chk("irq", 1, irq);
		apb(1, `CTBD_OFF_INT_DIV, 32'h1fff, 0);
		repeat (160) @(posedge pclk);
		apb(1, `CTBD_OFF_IRQ_STATUS, 3, 0);
		apb(0, `CTBD_OFF_IRQ_STATUS, 0, 33'h0);
		chk("irq", 0, irq);
		summarize();
	end
endmodule
`default_nettype wire
